// *** core/nsc_status_ecc.sv ***
module nsc_status_ecc
    import nsc_pkg::*;
#(
    parameter int RST_BUSY_CYC = RST_BUSY_CYC_DEF
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spi_sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe_n,
    input wire logic tgt_protected,
    input wire logic arr_done,
    input wire logic prog_fail_evt,
    input wire logic erase_fail_evt,
    input wire logic ecc_done,
    input wire logic [2:0] ecc_code_in,
    input wire logic [11:0] cache_wr_col,
    output logic arr_prog_go,
    output logic arr_read_go,
    output logic arr_erase_go,
    output logic arr_abort,
    output logic ecc_enc_go,
    output logic ecc_dec_go,
    output logic busy,
    output logic ecc_en,
    output logic [6:0] drv_pct,
    output logic cache_wr_ok
);
    localparam int CW = $clog2(RST_BUSY_CYC + 1);
    localparam logic [CW-1:0] CNT_END = CW'(RST_BUSY_CYC - 1);

    // ****************************************
    // Link side: frame decode on the bus clock
    // ****************************************
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [6:0] sh_reg;
    logic [7:0] op_reg;
    logic [15:0] tx_reg;
    logic tx_on_reg;
    nsc_req_t req_reg;
    logic req_tgl_reg;
    logic sn_s1_reg;
    logic sn_s2_reg;
    logic sn_ack_reg;
    nsc_snap_t shadow_reg;
    logic miso_reg;
    logic miso_oe_n_reg;
    nsc_snap_t snap_reg;
    logic sn_tgl_reg;

    wire logic [7:0] rx_byte = {sh_reg, mosi};
    wire logic byte_done = (bit_cnt_reg == BIT_LAST);
    wire nsc_cmd_t op_cmd_now = nsc_op_cmd(rx_byte);
    wire nsc_cmd_t op_cmd_held = nsc_op_cmd(op_reg);
    wire logic at_op = byte_done && (byte_cnt_reg == BYTE_OP);
    wire logic at_fa = byte_done && (byte_cnt_reg == BYTE_FA);
    wire logic issue_single = at_op && (op_cmd_now == CMD_ARM
        || op_cmd_now == CMD_DISARM || op_cmd_now == CMD_RESET);
    wire logic issue_fwr = byte_done && (byte_cnt_reg == BYTE_FD)
        && (op_cmd_held == CMD_FWR);
    wire logic issue_arr = byte_done && (byte_cnt_reg == BYTE_ADDR_END)
        && (op_cmd_held == CMD_PROG || op_cmd_held == CMD_FETCH
        || op_cmd_held == CMD_ERASE);
    wire logic issue = issue_single || issue_fwr || issue_arr;
    wire logic load_tx = at_fa && (op_reg == OP_FEAT_RD);
    // Drive and config are byte wide: repeat them to fill the word
    wire logic [15:0] feat_word =
        (rx_byte == FA_STATUS) ? shadow_reg.status :
        (rx_byte == FA_DRIVE) ? {2{shadow_reg.drive}} :
        (rx_byte == FA_CFG) ? {2{shadow_reg.cfg}} : '0;

    // Frame state is dropped by the frame's own select, not by sys_rst
    always_ff @(posedge spi_sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_cnt_reg <= '0;
            byte_cnt_reg <= '0;
            sh_reg <= '0;
            op_reg <= '0;
            tx_reg <= '0;
            tx_on_reg <= 1'b0;
        end
        else
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            sh_reg <= rx_byte[6:0];
            if (byte_done && byte_cnt_reg != BYTE_SAT)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            if (at_op)
                op_reg <= rx_byte;
            if (load_tx)
                tx_reg <= feat_word;
            else if (tx_on_reg)
                tx_reg <= {tx_reg[14:0], tx_reg[15]};
            if (load_tx)
                tx_on_reg <= 1'b1;
        end
    end

    // Crossing state must outlive frames, so it is held by sys_rst
    always_ff @(posedge spi_sck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_reg <= '0;
            req_tgl_reg <= 1'b0;
            sn_s1_reg <= 1'b0;
            sn_s2_reg <= 1'b0;
            sn_ack_reg <= 1'b0;
            shadow_reg <= '0;
        end
        else
        begin
            if (issue)
            begin
                req_reg.cmd <= issue_single ? op_cmd_now : op_cmd_held;
                req_reg.fdata <= rx_byte;
                req_tgl_reg <= ~req_tgl_reg;
            end
            else if (at_fa)
                req_reg.faddr <= rx_byte;
            sn_s1_reg <= sn_tgl_reg;
            sn_s2_reg <= sn_s1_reg;
            if (sn_s2_reg != sn_ack_reg)
            begin
                shadow_reg <= snap_reg;
                sn_ack_reg <= sn_s2_reg;
            end
        end
    end

    // Data changes on the falling edge so the host samples on rising
    always_ff @(negedge spi_sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            miso_reg <= 1'b0;
            miso_oe_n_reg <= 1'b1;
        end
        else
        begin
            miso_reg <= tx_reg[15];
            miso_oe_n_reg <= ~tx_on_reg;
        end
    end
    assign miso = miso_reg;
    assign miso_oe_n = miso_oe_n_reg;

    // ****************************************
    // Core side: crossing back in
    // ****************************************
    logic rq_s1_reg;
    logic rq_s2_reg;
    logic rq_seen_reg;
    logic ak_s1_reg;
    logic ak_s2_reg;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rq_s1_reg <= 1'b0;
            rq_s2_reg <= 1'b0;
            rq_seen_reg <= 1'b0;
            ak_s1_reg <= 1'b0;
            ak_s2_reg <= 1'b0;
        end
        else
        begin
            rq_s1_reg <= req_tgl_reg;
            rq_s2_reg <= rq_s1_reg;
            rq_seen_reg <= rq_s2_reg;
            ak_s1_reg <= sn_ack_reg;
            ak_s2_reg <= ak_s1_reg;
        end
    end

    // ****************************************
    // Core side: status, control and sequencing
    // ****************************************
    nsc_state_t st_reg;
    nsc_state_t st_next;
    logic pfail_reg;
    logic efail_reg;
    logic wel_reg;
    logic [2:0] ecc_code_reg;
    logic [7:0] drv_reg;
    logic [7:0] cfg_reg;
    logic op_ecc_reg;
    logic [CW-1:0] cnt_reg;
    logic busy_reg;
    logic prog_go_reg;
    logic read_go_reg;
    logic erase_go_reg;
    logic abort_reg;
    logic enc_go_reg;
    logic dec_go_reg;
    logic [6:0] drv_pct_reg;
    logic wr_ok_reg;

    wire logic new_req = rq_s2_reg ^ rq_seen_reg;
    wire logic idle = (st_reg == ST_IDLE);
    wire logic is_arm = new_req && req_reg.cmd == CMD_ARM;
    wire logic is_disarm = new_req && req_reg.cmd == CMD_DISARM;
    wire logic is_reset = new_req && req_reg.cmd == CMD_RESET;
    wire logic is_fwr = new_req && req_reg.cmd == CMD_FWR;
    wire logic try_prog = new_req && req_reg.cmd == CMD_PROG
        && idle && wel_reg;
    wire logic try_erase = new_req && req_reg.cmd == CMD_ERASE
        && idle && wel_reg;
    wire logic go_fetch = new_req && req_reg.cmd == CMD_FETCH && idle;
    wire logic go_prog = try_prog && !tgt_protected;
    wire logic go_erase = try_erase && !tgt_protected;
    wire logic ecc_on = cfg_reg[CFG_ECC_EN];
    wire logic enc_now = go_prog && ecc_on;
    wire logic wr_now = (go_prog && !ecc_on)
        || (st_reg == ST_ENC && ecc_done);
    wire logic dec_now = st_reg == ST_RD && arr_done && op_ecc_reg;
    wire logic fetch_end = st_reg == ST_RD && arr_done && !op_ecc_reg;
    wire logic dec_end = st_reg == ST_DEC && ecc_done;
    wire logic wr_end = (st_reg == ST_WR || st_reg == ST_ERS) && arr_done;
    wire logic rst_end = st_reg == ST_RST && cnt_reg == CNT_END;
    wire logic in_parity = cache_wr_col >= PAR_LO
        && cache_wr_col <= PAR_HI;
    // Clear first, set last: an event in the clearing cycle survives
    wire logic pfail_next = (pfail_reg && !try_prog && !is_reset)
        || prog_fail_evt || (try_prog && tgt_protected);
    wire logic efail_next = (efail_reg && !try_erase && !is_reset)
        || erase_fail_evt || (try_erase && tgt_protected);
    // A refused attempt uses up the latch, so status reads 08h or 04h
    wire logic wel_next = (wel_reg && !is_disarm && !wr_end
        && !(tgt_protected && (try_prog || try_erase)))
        || is_arm;
    wire logic [2:0] ecc_code_next = dec_end ? ecc_code_in :
        fetch_end ? ECC_NONE : ecc_code_reg;
    wire logic [15:0] status_word = {9'h0, ecc_code_reg, pfail_reg,
        efail_reg, wel_reg, busy_reg};

    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE:
            begin
                if (enc_now)
                    st_next = ST_ENC;
                else if (go_prog)
                    st_next = ST_WR;
                else if (go_fetch)
                    st_next = ST_RD;
                else if (go_erase)
                    st_next = ST_ERS;
            end
            ST_ENC: if (ecc_done) st_next = ST_WR;
            ST_WR: if (arr_done) st_next = ST_IDLE;
            ST_RD: if (arr_done) st_next = op_ecc_reg ? ST_DEC : ST_IDLE;
            ST_DEC: if (ecc_done) st_next = ST_IDLE;
            ST_ERS: if (arr_done) st_next = ST_IDLE;
            ST_RST: if (rst_end) st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
        if (is_reset)
            st_next = ST_RST;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= ST_IDLE;
            pfail_reg <= 1'b0;
            efail_reg <= 1'b0;
            wel_reg <= 1'b0;
            ecc_code_reg <= ECC_NONE;
            drv_reg <= DRV_RST;
            cfg_reg <= CFG_RST;
            op_ecc_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            pfail_reg <= pfail_next;
            efail_reg <= efail_next;
            wel_reg <= wel_next;
            ecc_code_reg <= ecc_code_next;
            if (is_fwr && req_reg.faddr == FA_DRIVE)
                drv_reg <= req_reg.fdata;
            if (is_fwr && req_reg.faddr == FA_CFG)
                cfg_reg <= req_reg.fdata;
            if (go_prog || go_fetch)
                op_ecc_reg <= ecc_on;
            cnt_reg <= (st_reg == ST_RST && !is_reset) ?
                cnt_reg + CW'(1) : '0;
        end
    end

    // Outputs, one flop each; start pulses last one cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            busy_reg <= 1'b0;
            prog_go_reg <= 1'b0;
            read_go_reg <= 1'b0;
            erase_go_reg <= 1'b0;
            abort_reg <= 1'b0;
            enc_go_reg <= 1'b0;
            dec_go_reg <= 1'b0;
            drv_pct_reg <= nsc_drv_pct(DRV_RST[DRV_DS_HI:DRV_DS_LO]);
            wr_ok_reg <= 1'b1;
        end
        else
        begin
            busy_reg <= (st_next != ST_IDLE);
            prog_go_reg <= wr_now && !is_reset;
            read_go_reg <= go_fetch && !is_reset;
            erase_go_reg <= go_erase && !is_reset;
            abort_reg <= is_reset;
            enc_go_reg <= enc_now && !is_reset;
            dec_go_reg <= dec_now && !is_reset;
            drv_pct_reg <= nsc_drv_pct(drv_reg[DRV_DS_HI:DRV_DS_LO]);
            wr_ok_reg <= !(ecc_on && in_parity);
        end
    end

    // Snapshot only reloads once the link side has taken the last one
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            snap_reg <= '0;
            sn_tgl_reg <= 1'b0;
        end
        else if (ak_s2_reg == sn_tgl_reg)
        begin
            snap_reg <= '{status: status_word, drive: drv_reg,
                cfg: cfg_reg};
            sn_tgl_reg <= ~sn_tgl_reg;
        end
    end

    assign busy = busy_reg;
    assign arr_prog_go = prog_go_reg;
    assign arr_read_go = read_go_reg;
    assign arr_erase_go = erase_go_reg;
    assign arr_abort = abort_reg;
    assign ecc_enc_go = enc_go_reg;
    assign ecc_dec_go = dec_go_reg;
    assign ecc_en = cfg_reg[CFG_ECC_EN];
    assign drv_pct = drv_pct_reg;
    assign cache_wr_ok = wr_ok_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_prog_locked;
        try_prog && tgt_protected && !is_reset;
    endsequence
    sequence s_prog_ecc;
        go_prog && ecc_on && !is_reset;
    endsequence

    chk_locked_prog_idle: assert property (
        s_prog_locked |=> !busy_reg && pfail_reg && !prog_go_reg && !wel_reg)
        else $error("locked program started or not flagged");
    chk_locked_erase_idle: assert property (
        try_erase && tgt_protected && !is_reset
        |=> !busy_reg && efail_reg && !erase_go_reg && !wel_reg)
        else $error("locked erase started or not flagged");
    chk_pfail_clear: assert property (
        go_prog && !prog_fail_evt && !is_reset |=> !pfail_reg)
        else $error("program fail not cleared at start");
    chk_reset_busy_clear: assert property (
        is_reset && !prog_fail_evt && !erase_fail_evt
        |=> busy_reg && !pfail_reg && !efail_reg && abort_reg)
        else $error("reset did not abort and clear");
    chk_write_latch_arm: assert property (
        is_arm |=> wel_reg) else $error("write latch not set");
    chk_write_latch_disarm: assert property (
        is_disarm && !is_arm |=> !wel_reg)
        else $error("write latch not cleared");
    chk_ecc_code_hold: assert property (
        !dec_end && !fetch_end |=> $stable(ecc_code_reg))
        else $error("correction code changed between fetches");
    chk_ecc_code_load: assert property (
        dec_end |=> ecc_code_reg == $past(ecc_code_in))
        else $error("correction code not captured");
    chk_encode_first: assert property (
        s_prog_ecc |=> enc_go_reg && !prog_go_reg && st_reg == ST_ENC)
        else $error("page written before encode");
    chk_encode_then_write: assert property (
        st_reg == ST_ENC && ecc_done && !is_reset |=> prog_go_reg)
        else $error("page not written after encode");
    chk_parity_block: assert property (
        ecc_on && in_parity |=> !wr_ok_reg)
        else $error("parity write allowed with correction on");
    chk_drive_map: assert property (
        drv_reg[DRV_DS_HI:DRV_DS_LO] == 2'h1 [*2] |-> drv_pct_reg == 7'd25)
        else $error("drive level mismatch");
endmodule

// *** core/nsc_pkg.sv ***
package nsc_pkg;
    // ****************************************
    // Opcodes and feature addresses
    // ****************************************
    localparam logic [7:0] OP_WR_ARM = 8'h06;
    localparam logic [7:0] OP_WR_DISARM = 8'h04;
    localparam logic [7:0] OP_FEAT_RD = 8'h0f;
    localparam logic [7:0] OP_FEAT_WR = 8'h1f;
    localparam logic [7:0] OP_PROG = 8'h10;
    localparam logic [7:0] OP_FETCH = 8'h13;
    localparam logic [7:0] OP_ERASE = 8'hd8;
    localparam logic [7:0] OP_RESET = 8'hff;
    localparam logic [7:0] FA_CFG = 8'hb0;
    localparam logic [7:0] FA_STATUS = 8'hc0;
    localparam logic [7:0] FA_DRIVE = 8'hd0;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_EFAIL = 2;
    localparam int ST_PFAIL = 3;
    localparam int ST_ECC_LO = 4;
    localparam int DRV_DS_LO = 5;
    localparam int DRV_DS_HI = 6;
    localparam int CFG_ECC_EN = 4;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h10;
    localparam logic [11:0] PAR_LO = 12'h840;
    localparam logic [11:0] PAR_HI = 12'h87f;
    localparam logic [2:0] ECC_NONE = 3'h0;
    localparam logic [2:0] ECC_FAIL = 3'h7;
    // ****************************************
    // Byte positions within a frame
    // ****************************************
    localparam logic [2:0] BYTE_OP = 3'h0;
    localparam logic [2:0] BYTE_FA = 3'h1;
    localparam logic [2:0] BYTE_FD = 3'h2;
    localparam logic [2:0] BYTE_ADDR_END = 3'h3;
    localparam logic [2:0] BYTE_SAT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // ****************************************
    // Timing
    // ****************************************
    localparam int RST_BUSY_US = 500;
    localparam int CLK_MHZ = 40;
    localparam int RST_BUSY_CYC_DEF = RST_BUSY_US * CLK_MHZ;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        CMD_NONE, CMD_ARM, CMD_DISARM, CMD_FWR,
        CMD_PROG, CMD_FETCH, CMD_ERASE, CMD_RESET
    } nsc_cmd_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_ENC = 3'b001, ST_WR = 3'b011,
        ST_RD = 3'b010, ST_DEC = 3'b110, ST_ERS = 3'b100,
        ST_RST = 3'b111
    } nsc_state_t;
    typedef struct packed {
        nsc_cmd_t cmd;
        logic [7:0] faddr;
        logic [7:0] fdata;
    } nsc_req_t;
    typedef struct packed {
        logic [15:0] status;
        logic [7:0] drive;
        logic [7:0] cfg;
    } nsc_snap_t;
    function automatic nsc_cmd_t nsc_op_cmd(input logic [7:0] op);
        case (op)
            OP_WR_ARM: nsc_op_cmd = CMD_ARM;
            OP_WR_DISARM: nsc_op_cmd = CMD_DISARM;
            OP_FEAT_WR: nsc_op_cmd = CMD_FWR;
            OP_PROG: nsc_op_cmd = CMD_PROG;
            OP_FETCH: nsc_op_cmd = CMD_FETCH;
            OP_ERASE: nsc_op_cmd = CMD_ERASE;
            OP_RESET: nsc_op_cmd = CMD_RESET;
            default: nsc_op_cmd = CMD_NONE;
        endcase
    endfunction
    function automatic logic [6:0] nsc_drv_pct(input logic [1:0] ds);
        case (ds)
            2'h0: nsc_drv_pct = 7'd50;
            2'h1: nsc_drv_pct = 7'd25;
            2'h2: nsc_drv_pct = 7'd75;
            default: nsc_drv_pct = 7'd100;
        endcase
    endfunction
endpackage

// *** sim/nsc_host_model.sv ***
module nsc_host_model
(
    output logic spi_sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        spi_sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // ****************************************
    // One framed transfer, mode 0, MSB first
    // ****************************************
    // Link clock only runs inside a frame; last 16 bits seen come back
    task automatic frame(input logic [31:0] tx, input int nb,
        output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--)
        begin
            mosi = tx[i];
            #32;
            spi_sck = 1'b1;
            rx = {rx[14:0], miso};
            #32;
            spi_sck = 1'b0;
        end
        #10;
        cs_n = 1'b1;
        // Released line must not keep a stale bit
        mosi = ~mosi;
        #40;
    endtask
endmodule

// *** sim/nsc_status_ecc_tb_top.sv ***
module nsc_status_ecc_tb_top import nsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ARR_DLY = 200;
    localparam int WDOG_NS = 600000;
    typedef struct packed {
        logic [7:0] fa;
        logic [7:0] fd;
        logic [11:0] col;
        logic [6:0] pct;
        logic en;
        logic ok;
    } nsc_row_t;
    nsc_row_t rows [6] = '{'{8'hb0, 8'h00, 12'h840, 7'h32, 1'b0, 1'b1},
        '{8'hb0, 8'h10, 12'h840, 7'h32, 1'b1, 1'b0},
        '{8'hd0, 8'h00, 12'h87f, 7'h32, 1'b1, 1'b0},
        '{8'hd0, 8'h20, 12'h83f, 7'h19, 1'b1, 1'b1},
        '{8'hd0, 8'h40, 12'h880, 7'h4b, 1'b1, 1'b1},
        '{8'hd0, 8'h60, 12'h000, 7'h64, 1'b1, 1'b1}};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tgt_protected = 1'b0;
    logic arr_done = 1'b0;
    logic prog_fail_evt = 1'b0;
    logic erase_fail_evt = 1'b0;
    logic ecc_done = 1'b0;
    logic [2:0] ecc_code_in = 3'h0;
    logic [11:0] cache_wr_col = 12'h000;
    logic inj_fail = 1'b0;
    logic prog_run = 1'b0;
    logic spi_sck, cs_n, mosi, miso, miso_oe_n, arr_prog_go, arr_read_go;
    logic arr_erase_go, arr_abort, ecc_enc_go, ecc_dec_go, busy, ecc_en;
    logic cache_wr_ok;
    logic [6:0] drv_pct;
    int arr_cnt = 0;
    int ecc_cnt = 0;
    int enc_n = 0;
    int dec_n = 0;
    int abort_n = 0;
    int err_total = 0;
    int compares = 0;
    int oe_cnt = 0;
    always #12.5 core_clk = ~core_clk;
    // Count bit times in which the device drives the data line
    always @(posedge spi_sck)
        if (!miso_oe_n)
            oe_cnt <= oe_cnt + 1;
    nsc_host_model nsc_host_model_inst (.spi_sck(spi_sck), .cs_n(cs_n),
        .mosi(mosi), .miso(miso));
    nsc_status_ecc #(.RST_BUSY_CYC(16)) nsc_status_ecc_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
        .tgt_protected(tgt_protected), .arr_done(arr_done),
        .prog_fail_evt(prog_fail_evt), .erase_fail_evt(erase_fail_evt),
        .ecc_done(ecc_done), .ecc_code_in(ecc_code_in),
        .cache_wr_col(cache_wr_col), .arr_prog_go(arr_prog_go),
        .arr_read_go(arr_read_go), .arr_erase_go(arr_erase_go),
        .arr_abort(arr_abort), .ecc_enc_go(ecc_enc_go),
        .ecc_dec_go(ecc_dec_go), .busy(busy), .ecc_en(ecc_en),
        .drv_pct(drv_pct), .cache_wr_ok(cache_wr_ok));
    // ****************************************
    // Array and corrector stand-in
    // ****************************************
    // Array time outlasts a status read frame so busy can be seen
    always @(posedge core_clk)
    begin
        arr_done <= (arr_cnt == 1);
        ecc_done <= (ecc_cnt == 1);
        prog_fail_evt <= (arr_cnt == 1) & inj_fail & prog_run;
        erase_fail_evt <= (arr_cnt == 1) & inj_fail & ~prog_run;
        arr_cnt <= (arr_cnt > 0) ? arr_cnt - 1 : 0;
        ecc_cnt <= (ecc_cnt > 0) ? ecc_cnt - 1 : 0;
        if (arr_prog_go | arr_read_go | arr_erase_go)
            arr_cnt <= ARR_DLY;
        if (ecc_enc_go | ecc_dec_go)
            ecc_cnt <= 8;
        if (arr_prog_go | arr_erase_go)
            prog_run <= arr_prog_go;
        // Abort stops the array and corrector, no stray done later
        if (arr_abort)
        begin
            arr_cnt <= 0;
            ecc_cnt <= 0;
        end
        enc_n <= enc_n + int'(ecc_enc_go);
        dec_n <= dec_n + int'(ecc_dec_go);
        abort_n <= abort_n + int'(arr_abort);
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [31:0] tx, input int nb);
        logic [15:0] r;
        nsc_host_model_inst.frame(tx, nb, r);
        repeat (10) @(negedge core_clk);
    endtask
    task automatic rdchk(input logic [7:0] fa, input logic [15:0] exp);
        logic [15:0] r;
        int n0;
        n0 = oe_cnt;
        nsc_host_model_inst.frame({OP_FEAT_RD, fa, 16'h0000}, 32, r);
        repeat (10) @(negedge core_clk);
        chk(r, exp);
        chk(16'(oe_cnt - n0), 16'h0010);
        chk({15'h0, miso_oe_n}, 16'h0001);
    endtask
    task automatic op32(input logic [7:0] op);
        send({op, 24'h000000}, 32);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0, busy}, 16'h0000);
    endtask
    task automatic stop_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #(WDOG_NS);
        err_total++;
        stop_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk({9'h0, drv_pct, ecc_en}, 16'h0065);
        rdchk(FA_STATUS, 16'h0000);
        foreach (rows[i])
        begin
            send({8'h00, OP_FEAT_WR, rows[i].fa, rows[i].fd}, 24);
            @(posedge core_clk) cache_wr_col <= rows[i].col;
            rdchk(rows[i].fa, {rows[i].fd, rows[i].fd});
            chk({drv_pct, ecc_en, cache_wr_ok}, {rows[i][8:0]});
        end
        $display("row table done");
        op32(OP_FETCH);
        wait_idle();
        send(32'h6, 8);
        rdchk(FA_STATUS, 16'h0002);
        send(32'h4, 8);
        rdchk(FA_STATUS, 16'h0000);
        op32(OP_PROG);
        rdchk(FA_STATUS, 16'h0000);
        send(32'h6, 8);
        op32(OP_PROG);
        rdchk(FA_STATUS, 16'h0003);
        wait_idle();
        chk(enc_n[15:0], 16'h0001);
        @(posedge core_clk) inj_fail <= 1'b1;
        send(32'h6, 8);
        op32(OP_PROG);
        wait_idle();
        rdchk(FA_STATUS, 16'h0008);
        send(32'h6, 8);
        op32(OP_ERASE);
        wait_idle();
        rdchk(FA_STATUS, 16'h000c);
        @(posedge core_clk) inj_fail <= 1'b0;
        send(32'h6, 8);
        op32(OP_ERASE);
        rdchk(FA_STATUS, 16'h000b);
        wait_idle();
        send(32'h6, 8);
        op32(OP_PROG);
        rdchk(FA_STATUS, 16'h0003);
        send(32'hff, 8);
        wait_idle();
        rdchk(FA_STATUS, 16'h0002);
        chk(abort_n[15:0], 16'h0001);
        $display("program and erase flags done");
        @(posedge core_clk) tgt_protected <= 1'b1;
        send(32'h6, 8);
        op32(OP_PROG);
        chk({15'h0, busy}, 16'h0000);
        rdchk(FA_STATUS, 16'h0008);
        send(32'hff, 8);
        wait_idle();
        send(32'h6, 8);
        op32(OP_ERASE);
        rdchk(FA_STATUS, 16'h0004);
        @(posedge core_clk) tgt_protected <= 1'b0;
        $display("locked target done");
        for (int c = 0; c < 8; c++)
        begin
            @(posedge core_clk) ecc_code_in <= 3'(c);
            op32(OP_FETCH);
            wait_idle();
            @(posedge core_clk) ecc_code_in <= ~3'(c);
            rdchk(FA_STATUS, {9'h0, 3'(c), 4'h4});
        end
        chk(dec_n[15:0], 16'h0009);
        send({8'h00, OP_FEAT_WR, FA_CFG, 8'h00}, 24);
        op32(OP_FETCH);
        wait_idle();
        rdchk(FA_STATUS, 16'h0004);
        chk(dec_n[15:0], 16'h0009);
        $display("correction code done");
        @(posedge core_clk) sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk({9'h0, drv_pct, ecc_en}, 16'h0065);
        rdchk(FA_STATUS, 16'h0000);
        $display("mid-run reset done");
        stop_test();
    end
endmodule
